// ===== design/i2cm_pkg.sv
package i2cm_pkg;

	// Bus rate: standard mode only, fast mode is never generated
	localparam int CLK_PERIOD_NS  = 10;
	localparam int BIT_RATE_KBPS  = 100;
	localparam int T_BIT_NS       = 1000000 / BIT_RATE_KBPS;
	localparam int T_QTR_NS       = T_BIT_NS / 4;
	// Least time per quarter bit, rounded up to whole cycles
	localparam int QTR_CYC        = (T_QTR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int QTR_W          = 8;
	localparam logic [QTR_W-1:0] QTR_LAST = QTR_W'(QTR_CYC - 1);

	// Byte framing: eight data bits then the acknowledge bit
	localparam int BIT_W          = 4;
	localparam logic [BIT_W-1:0] BIT_ACK  = 4'h8;
	localparam logic [BIT_W-1:0] BIT_ZERO = 4'h0;
	localparam logic [BIT_W-1:0] BIT_ONE  = 4'h1;

	// First five bits of the first byte of an extended address
	localparam logic [4:0] TENBIT_PREFIX = 5'h1e;

	// Far device control register layout, kept for software reference
	localparam int PORT_CLK_RELEASE_BIT = 4;
	localparam int PORT_ENABLE_BIT      = 5;

	// Response buffer shape
	localparam int RSP_DEPTH = 2;

	// One command: optional start, at most one byte, optional stop
	typedef struct packed {
		logic       start;
		logic       stop;
		logic       rd;
		logic       nack;
		logic       has_byte;
		logic [7:0] data;
	} i2cm_cmd_s;

	// One answer per byte moved on the bus
	typedef struct packed {
		logic [7:0] data;
		logic       nack;
		logic       arb_lost;
	} i2cm_rsp_s;

	localparam int RSP_W = $bits(i2cm_rsp_s);

	typedef enum logic [3:0] {
		ST_IDLE  = 4'h0,
		ST_SA    = 4'h1,
		ST_SB    = 4'h2,
		ST_HOLD  = 4'h3,
		ST_RSA   = 4'h4,
		ST_RSB   = 4'h5,
		ST_RSC   = 4'h6,
		ST_LO    = 4'h7,
		ST_SETUP = 4'h8,
		ST_RISE  = 4'h9,
		ST_HIGH  = 4'ha,
		ST_PA    = 4'hb,
		ST_PB    = 4'hc,
		ST_PC    = 4'hd,
		ST_PD    = 4'he
	} i2cm_state_e;

endpackage

// ===== design/i2cm_sync.sv
`timescale 1ns/100ps
module i2cm_sync
	import i2cm_pkg::*;
#(
	parameter int W = 2
) (
	input  wire logic         ref_clk_in,
	input  wire logic         rstn_in,
	input  wire logic [W-1:0] d_in,
	output logic      [W-1:0] q_out
);

	logic [W-1:0] meta_q;

	// Two flops per line; lines idle high, so reset to one
	generate
		for (genvar i = 0; i < W; i++) begin : g_bit
			always_ff @(posedge ref_clk_in or negedge rstn_in) begin
				if (!rstn_in) begin
					meta_q[i] <= 1'b1;
					q_out[i]  <= 1'b1;
				end else begin
					meta_q[i] <= d_in[i];
					q_out[i]  <= meta_q[i];
				end
			end
		end
	endgenerate

endmodule

// ===== design/i2cm_fifo.sv
`timescale 1ns/100ps
module i2cm_fifo
	import i2cm_pkg::*;
#(
	parameter int W     = RSP_W,
	parameter int DEPTH = RSP_DEPTH
) (
	input  wire logic         ref_clk_in,
	input  wire logic         rstn_in,
	input  wire logic         in_valid_in,
	output logic              in_ready_out,
	input  wire logic [W-1:0] in_data_in,
	output logic              out_valid_out,
	input  wire logic         out_ready_in,
	output logic      [W-1:0] out_data_out
);

	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH - 1);
	localparam logic [AW:0]   CNT_FULL = (AW + 1)'(DEPTH);

	logic [W-1:0]  mem_q [DEPTH];
	logic [AW-1:0] wr_ptr_q;
	logic [AW-1:0] rd_ptr_q;
	logic [AW:0]   count_q;
	logic          push;
	logic          pop;

	// Full and empty come straight from the occupancy count
	assign in_ready_out  = (count_q != CNT_FULL);
	assign out_valid_out = (count_q != '0);
	assign out_data_out  = mem_q[rd_ptr_q];
	assign push          = in_valid_in && in_ready_out;
	assign pop           = out_valid_out && out_ready_in;

	// Storage is written only, never reset, to keep it cheap
	always_ff @(posedge ref_clk_in) begin
		if (push) begin
			mem_q[wr_ptr_q] <= in_data_in;
		end
	end

	// Pointers wrap at the depth, which need not be a power of two
	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			count_q  <= '0;
		end else begin
			if (push) begin
				wr_ptr_q <= (wr_ptr_q == PTR_LAST) ? '0 : wr_ptr_q + 1'b1;
			end
			if (pop) begin
				rd_ptr_q <= (rd_ptr_q == PTR_LAST) ? '0 : rd_ptr_q + 1'b1;
			end
			if (push && !pop) begin
				count_q <= count_q + 1'b1;
			end else if (pop && !push) begin
				count_q <= count_q - 1'b1;
			end
		end
	end

endmodule

// ===== design/i2cm_master.sv
// How it works
// - Clock bytes at standard rate, tolerate faster devices
// - Master always drives clock, opposite data role
// - Pins only pull low or release
// - Idle bus: both lines released
// - Start is data falling while clock high
// - Stop is data rising while clock high
// - Data changes only while clock low
// - First byte carries address and direction
// - Whole bytes, no limit per transfer
// - Unacknowledged write forces a stop
// - Read acks all bytes except last
// - Stop after acknowledge is valid termination
// - Wait while the clock line is held low
// - Repeated start after acknowledge keeps the bus
// - Losing arbitration switches data output off
// - After loss, clock only to byte end
`timescale 1ns/100ps
module i2cm_master
	import i2cm_pkg::*;
(
	input  wire logic      ref_clk_in,
	input  wire logic      rstn_in,
	input  wire logic      en_in,
	input  wire logic      cmd_valid_in,
	output logic           cmd_ready_out,
	input  wire i2cm_cmd_s cmd_in,
	output logic           rsp_valid_out,
	input  wire logic      rsp_ready_in,
	output i2cm_rsp_s      rsp_out,
	output logic           busy_out,
	input  wire logic      scl_in,
	output logic           scl_out,
	output logic           scl_oe_out,
	input  wire logic      sda_in,
	output logic           sda_out,
	output logic           sda_oe_out
);

	i2cm_state_e      state_q;
	i2cm_cmd_s        cmd_q;
	logic [QTR_W-1:0] div_q;
	logic             tick;
	logic [1:0]       line_s;
	logic             scl_s;
	logic             sda_s;
	logic             scl_p_q;
	logic             sda_p_q;
	logic             start_det;
	logic             stop_det;
	logic             busy_q;
	logic             scl_low_q;
	logic             sda_low_q;
	logic [7:0]       shift_q;
	logic [BIT_W-1:0] bit_q;
	logic             lost_q;
	logic             take;
	logic             rsp_push;
	logic             rsp_room;
	logic             rsp_in_ready;
	logic             drive_bit;
	logic             ack_bit;
	logic             wr_nack;
	i2cm_rsp_s        rsp_d;

	// Both lines pass two flops before anything reads them
	i2cm_sync #(
		.W(2)
	) u_sync (
		.ref_clk_in(ref_clk_in),
		.rstn_in   (rstn_in),
		.d_in      ({scl_in, sda_in}),
		.q_out     (line_s)
	);

	assign scl_s = line_s[1];
	assign sda_s = line_s[0];

	// Open drain: the pad level is always low, only the enable moves
	assign scl_out    = 1'b0;
	assign sda_out    = 1'b0;
	assign scl_oe_out = scl_low_q;
	assign sda_oe_out = sda_low_q;
	assign busy_out   = busy_q;

	// Quarter-bit enable; four quarters plus stretch make one bit
	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			div_q <= '0;
		end else if (div_q == QTR_LAST) begin
			div_q <= '0;
		end else begin
			div_q <= div_q + 1'b1;
		end
	end

	assign tick = (div_q == QTR_LAST);

	// Start and stop seen on the bus, from any master
	assign start_det = scl_s && scl_p_q && sda_p_q && !sda_s;
	assign stop_det  = scl_s && scl_p_q && !sda_p_q && sda_s;

	// Bus busy tracking lets us wait out another master's frame
	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			scl_p_q <= 1'b1;
			sda_p_q <= 1'b1;
			busy_q  <= 1'b0;
		end else begin
			scl_p_q <= scl_s;
			sda_p_q <= sda_s;
			if (start_det) begin
				busy_q <= 1'b1;
			end else if (stop_det) begin
				busy_q <= 1'b0;
			end
		end
	end

	// A byte command needs buffer room first, so a slow reader stalls
	// the bus with the clock held low instead of losing a word
	assign rsp_room      = !cmd_in.has_byte || rsp_in_ready;
	assign cmd_ready_out = en_in && rsp_room && (state_q == ST_IDLE || state_q == ST_HOLD);
	assign take          = cmd_valid_in && cmd_ready_out;

	// Pull-low enable for data during the low phase of the current bit
	assign ack_bit   = cmd_q.rd && !cmd_q.nack && !lost_q;
	assign drive_bit = (bit_q == BIT_ACK) ? ack_bit
	                 : (!cmd_q.rd && !lost_q && !shift_q[7]);
	// Write byte refused when data stays high in the ninth clock
	assign wr_nack   = !cmd_q.rd && sda_s;

	// Bus sequencer and line drivers
	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			state_q   <= ST_IDLE;
			scl_low_q <= 1'b0;
			sda_low_q <= 1'b0;
		end else if (!en_in) begin
			state_q   <= ST_IDLE;
			scl_low_q <= 1'b0;
			sda_low_q <= 1'b0;
		end else begin
			unique case (state_q)
				ST_IDLE: begin
					scl_low_q <= 1'b0;
					sda_low_q <= 1'b0;
					if (take && cmd_in.has_byte) begin
						state_q <= ST_SA;
					end
				end
				ST_SA: if (tick && scl_s && sda_s && !busy_q) begin
					sda_low_q <= 1'b1;
					state_q   <= ST_SB;
				end
				ST_SB: if (tick) begin
					scl_low_q <= 1'b1;
					state_q   <= ST_LO;
				end
				ST_HOLD: if (take) begin
					if (cmd_in.has_byte) begin
						state_q <= cmd_in.start ? ST_RSA : ST_LO;
					end else if (cmd_in.stop) begin
						state_q <= ST_PA;
					end
				end
				ST_RSA: if (tick) begin
					sda_low_q <= 1'b0;
					state_q   <= ST_RSB;
				end
				ST_RSB: if (tick) begin
					scl_low_q <= 1'b0;
					state_q   <= ST_RSC;
				end
				ST_RSC: if (tick && scl_s && sda_s) begin
					sda_low_q <= 1'b1;
					state_q   <= ST_SB;
				end
				ST_LO: if (tick) begin
					sda_low_q <= drive_bit;
					state_q   <= ST_SETUP;
				end
				ST_SETUP: if (tick) begin
					scl_low_q <= 1'b0;
					state_q   <= ST_RISE;
				end
				ST_RISE: if (tick && scl_s) begin
					state_q <= ST_HIGH;
				end
				ST_HIGH: if (tick) begin
					scl_low_q <= 1'b1;
					if (bit_q != BIT_ACK) begin
						state_q <= ST_LO;
						if (lost_q || (!cmd_q.rd && !sda_low_q && !sda_s)) begin
							sda_low_q <= 1'b0;
						end
					end else if (lost_q) begin
						scl_low_q <= 1'b0;
						sda_low_q <= 1'b0;
						state_q   <= ST_IDLE;
					end else if (wr_nack || cmd_q.stop) begin
						state_q <= ST_PA;
					end else begin
						state_q <= ST_HOLD;
					end
				end
				// Stop always follows the ack clock, never cuts into it
				ST_PA: if (tick) begin
					sda_low_q <= 1'b1;
					state_q   <= ST_PB;
				end
				ST_PB: if (tick) begin
					scl_low_q <= 1'b0;
					state_q   <= ST_PC;
				end
				ST_PC: if (tick && scl_s) begin
					sda_low_q <= 1'b0;
					state_q   <= ST_PD;
				end
				ST_PD: if (tick) begin
					state_q <= ST_IDLE;
				end
				default: begin
					scl_low_q <= 1'b0;
					sda_low_q <= 1'b0;
					state_q   <= ST_IDLE;
				end
			endcase
		end
	end

	// Command latch; held for the whole byte and its stop decision
	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			cmd_q <= '0;
		end else if (take) begin
			cmd_q <= cmd_in;
		end
	end

	// Shift, bit count and arbitration; sampled at the end of clock-high
	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			shift_q <= '0;
			bit_q   <= BIT_ZERO;
			lost_q  <= 1'b0;
		end else if (take && cmd_in.has_byte) begin
			shift_q <= cmd_in.data;
			bit_q   <= BIT_ZERO;
			lost_q  <= 1'b0;
		end else if (state_q == ST_HIGH && tick && bit_q != BIT_ACK) begin
			shift_q <= {shift_q[6:0], sda_s};
			bit_q   <= bit_q + BIT_ONE;
			if (!cmd_q.rd && !sda_low_q && !sda_s) begin
				lost_q <= 1'b1;
			end
		end
	end

	// One answer per byte, pushed as the ninth clock is sampled
	assign rsp_push       = (state_q == ST_HIGH) && tick && (bit_q == BIT_ACK);
	assign rsp_d.data     = shift_q;
	assign rsp_d.nack     = cmd_q.rd ? cmd_q.nack : sda_s;
	assign rsp_d.arb_lost = lost_q;

	i2cm_fifo #(
		.W    (RSP_W),
		.DEPTH(RSP_DEPTH)
	) u_rsp_fifo (
		.ref_clk_in   (ref_clk_in),
		.rstn_in      (rstn_in),
		.in_valid_in  (rsp_push),
		.in_ready_out (rsp_in_ready),
		.in_data_in   (rsp_d),
		.out_valid_out(rsp_valid_out),
		.out_ready_in (rsp_ready_in),
		.out_data_out (rsp_out)
	);

	// Checks on the driven lines
	localparam int QMAX = 260;
	localparam int SMAX = 520;

	default clocking cb @(posedge ref_clk_in);
	endclocking
	default disable iff (!rstn_in);

	open_drain_a: assert property (!scl_out && !sda_out)
		else $error("pad driven high");
	idle_release_a: assert property (
		(state_q == ST_IDLE) && $past(state_q) == ST_IDLE |-> !scl_oe_out && !sda_oe_out)
		else $error("line held in idle");
	data_stable_a: assert property (
		$changed(sda_oe_out) && state_q inside {ST_SETUP, ST_HOLD} |-> scl_oe_out)
		else $error("data moved with clock high");
	start_seq_a: assert property (
		$rose(sda_oe_out) && !scl_oe_out && state_q == ST_SB |-> ##[1:QMAX] scl_oe_out)
		else $error("clock not pulled after start");
	stop_seq_a: assert property (
		$fell(sda_oe_out) && !scl_oe_out && state_q == ST_PD |-> ##[1:QMAX] state_q == ST_IDLE)
		else $error("stop not followed by idle");
	arb_off_a: assert property (
		lost_q && state_q == ST_LO |=> !sda_oe_out)
		else $error("data driven after loss");
	arb_byte_a: assert property (
		lost_q && state_q == ST_HIGH && tick && bit_q == BIT_ACK |=> state_q == ST_IDLE
		##1 !scl_oe_out)
		else $error("clocking beyond lost byte");
	stretch_wait_a: assert property (
		state_q == ST_RISE && !scl_s |=> state_q == ST_RISE && !scl_oe_out)
		else $error("stretch not honoured");
	nack_stop_a: assert property (
		state_q == ST_HIGH && tick && bit_q == BIT_ACK && !lost_q && wr_nack
		|=> state_q == ST_PA ##[1:SMAX] $rose(sda_oe_out))
		else $error("no stop after nack");
	rep_start_a: assert property (
		state_q == ST_RSC && tick && scl_s && sda_s |=> state_q == ST_SB && sda_oe_out)
		else $error("repeated start lost");

	start_c: cover property (state_q == ST_SA ##[1:QMAX] state_q == ST_SB);
	rstart_c: cover property (state_q == ST_RSC ##1 state_q == ST_SB);
	lost_c: cover property ($rose(lost_q));
	stretch_c: cover property (state_q == ST_RISE && !scl_s && tick);

endmodule

// ===== sim/i2cm_slave_model.sv
`timescale 1ns/100ps
module i2cm_slave_model #(
	parameter logic [6:0] ADDR   = 7'h52,
	parameter logic [7:0] DATA0  = 8'hc3,
	parameter int         STR_NS = 4000
) (
	input  wire logic  scl_in,
	input  wire logic  sda_in,
	output logic       scl_oe_out,
	output logic       sda_oe_out,
	output logic [7:0] wr_byte_out
);
	logic       rs_q;
	logic [7:0] tx_q;

	// Shift one byte in on clock rises, return at the following fall
	task automatic rx(output logic [7:0] b);
		for (int i = 0; i < 8; i++) begin
			@(posedge scl_in);
			b = {b[6:0], sda_in};
		end
		@(negedge scl_in);
	endtask

	// Receiving never stretches, as the release bit is left set
	task automatic ack();
		#20 sda_oe_out = 1'b1;
		@(negedge scl_in);
		#20 sda_oe_out = 1'b0;
	endtask

	// One frame: address byte, then writes or reads until the frame ends
	task automatic serve();
		logic [7:0] b;
		rx(b);
		// General call and foreign addresses leave the data line high
		if (b[7:1] !== ADDR) return;
		ack();
		if (!b[0]) begin
			forever begin
				rx(b);
				wr_byte_out = b;
				ack();
			end
		end
		forever begin
			// Fetching the byte costs time, so the clock is held low meanwhile
			scl_oe_out = 1'b1;
			#STR_NS;
			for (int i = 7; i >= 0; i--) begin
				sda_oe_out = !tx_q[i];
				scl_oe_out = 1'b0;
				@(negedge scl_in);
				#20;
			end
			sda_oe_out = 1'b0;
			@(posedge scl_in);
			b[0] = sda_in;
			tx_q = tx_q + 8'h01;
			@(negedge scl_in);
			#20;
			// Not-acknowledge ends the read with the data line released
			if (b[0]) return;
		end
	endtask

	// Port taken as enabled, release bit set, for the whole run
	// Frames open on a start and close on a stop or a repeated start
	initial begin
		sda_oe_out = 1'b0;
		scl_oe_out = 1'b0;
		wr_byte_out = 8'h00;
		tx_q = DATA0;
		rs_q = 1'b0;
		forever begin
			if (!rs_q) @(negedge sda_in iff scl_in === 1'b1);
			rs_q = 1'b0;
			fork : frame
				serve();
				@(posedge sda_in iff scl_in === 1'b1);
				begin
					@(negedge sda_in iff scl_in === 1'b1);
					rs_q = 1'b1;
				end
			join_any
			disable frame;
			sda_oe_out = 1'b0;
			scl_oe_out = 1'b0;
		end
	end
endmodule

// ===== sim/testbench.sv
`timescale 1ns/100ps
module testbench
	import i2cm_pkg::*;
;
	logic       clk, rstn, en, cmd_valid, cmd_ready, rsp_valid, rsp_ready, busy;
	i2cm_cmd_s  cmd;
	i2cm_rsp_s  rsp;
	logic       m_scl_oe, m_sda_oe, s_scl_oe, s_sda_oe, tb_sda_oe;
	logic [7:0] wr_byte;
	int         n_mismatch, cmp_count;
	int         cyc = 0;
	time        t_last = 0;
	time        t_min = 1000000;
	// Wired-AND lines with pull-ups
	wire        scl = !(m_scl_oe | s_scl_oe);
	wire        sda = !(m_sda_oe | s_sda_oe | tb_sda_oe);

	i2cm_master dut (.ref_clk_in(clk), .rstn_in(rstn), .en_in(en),
		.cmd_valid_in(cmd_valid), .cmd_ready_out(cmd_ready), .cmd_in(cmd),
		.rsp_valid_out(rsp_valid), .rsp_ready_in(rsp_ready), .rsp_out(rsp),
		.busy_out(busy), .scl_in(scl), .scl_out(), .scl_oe_out(m_scl_oe),
		.sda_in(sda), .sda_out(), .sda_oe_out(m_sda_oe));

	i2cm_slave_model slv (.scl_in(scl), .sda_in(sda), .scl_oe_out(s_scl_oe),
		.sda_oe_out(s_sda_oe), .wr_byte_out(wr_byte));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// Shortest clock period seen on the wire, stretches only lengthen it
	always @(posedge scl) begin
		if (t_last != 0 && $time - t_last < t_min) t_min = $time - t_last;
		t_last = $time;
	end

	// Cut a hang short
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 99000) begin
			n_mismatch++;
			close_out();
		end
	end

	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic offer(input i2cm_cmd_s c);
		@(negedge clk);
		cmd = c;
		cmd_valid = 1'b1;
	endtask

	task automatic take();
		while (cmd_ready !== 1'b1) @(negedge clk);
		@(negedge clk);
		cmd_valid = 1'b0;
	endtask

	task automatic send(input i2cm_cmd_s c);
		offer(c);
		take();
	endtask

	// Pop one answer; data and nack are skipped where they are undefined
	task automatic get_rsp(input logic [7:0] d, input logic nk, input logic al, input logic ck);
		@(negedge clk);
		rsp_ready = 1'b1;
		while (rsp_valid !== 1'b1) @(negedge clk);
		if (ck) check("rsp data", rsp.data, d);
		if (ck) check("rsp nack", {7'h00, rsp.nack}, {7'h00, nk});
		check("rsp arb", {7'h00, rsp.arb_lost}, {7'h00, al});
		@(negedge clk);
		rsp_ready = 1'b0;
	endtask

	// After a stop both lines must be left to the pull-ups
	task automatic wait_idle();
		while (busy !== 1'b0) @(negedge clk);
		repeat (600) @(negedge clk);
		check("scl drive", {7'h00, m_scl_oe}, 8'h00);
		check("sda drive", {7'h00, m_sda_oe}, 8'h00);
	endtask

	task automatic write_stop();
		send(13'h11a4);
		send(13'h095a);
		get_rsp(8'ha4, 1'b0, 1'b0, 1'b1);
		get_rsp(8'h5a, 1'b0, 1'b0, 1'b1);
		check("slave byte", wr_byte, 8'h5a);
		wait_idle();
	endtask

	// Reader left unread: third byte must wait with the clock held low
	task automatic read_rs();
		send(13'h11a4);
		send(13'h11a5);
		offer(13'h0f00);
		repeat (12000) @(negedge clk);
		check("ready full", {7'h00, cmd_ready}, 8'h00);
		check("scl held", {7'h00, scl}, 8'h00);
		get_rsp(8'ha4, 1'b0, 1'b0, 1'b1);
		take();
		get_rsp(8'ha5, 1'b0, 1'b0, 1'b1);
		get_rsp(8'hc3, 1'b1, 1'b0, 1'b1);
		check("slave sda", {7'h00, s_sda_oe}, 8'h00);
		wait_idle();
	endtask

	task automatic gc_nack();
		send(13'h1100);
		get_rsp(8'h00, 1'b1, 1'b0, 1'b1);
		wait_idle();
	endtask

	// A rival master pulls the first address bit low, then closes the frame
	task automatic arb_loss();
		send(13'h19a4);
		@(negedge scl);
		@(negedge clk);
		tb_sda_oe = 1'b1;
		@(negedge scl);
		@(negedge clk);
		tb_sda_oe = 1'b0;
		get_rsp(8'h00, 1'b0, 1'b1, 1'b0);
		while (m_scl_oe !== 1'b0 || scl !== 1'b1) @(negedge clk);
		repeat (300) @(negedge clk);
		tb_sda_oe = 1'b1;
		repeat (300) @(negedge clk);
		tb_sda_oe = 1'b0;
		wait_idle();
	endtask

	task automatic close_out();
		$display("checks %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// Main sequence
	initial begin
		rstn = 1'b0;
		en = 1'b1;
		cmd_valid = 1'b0;
		cmd = '0;
		rsp_ready = 1'b0;
		tb_sda_oe = 1'b0;
		n_mismatch = 0;
		cmp_count = 0;
		repeat (12) @(negedge clk);
		rstn = 1'b1;
		@(negedge clk);
		check("busy idle", {7'h00, busy}, 8'h00);
		write_stop();
		read_rs();
		gc_nack();
		arb_loss();
		check("min period", {7'h00, t_min >= 10000}, 8'h01);
		close_out();
	end
endmodule
